/* File: include/cfrx_map.svh */
`ifndef CFRX_MAP_SVH
`define CFRX_MAP_SVH

// printed offsets are word indices; byte address is four times the index
`define CFRX_IDX_FILT3_VAL 8'h50
`define CFRX_IDX_RANGE_LOW 8'h54
`define CFRX_IDX_RANGE_HIGH 8'h58
`define CFRX_IDX_ACCEPT 8'h5c
`define CFRX_IDX_PRESENT 8'h5e
`define CFRX_IDX_MEMINFO 8'h60
`define CFRX_IDX_POINTERS 8'h64
`define CFRX_IDX_STATUS 8'h68
`define CFRX_IDX_OPTIONS 8'h6a
`define CFRX_IDX_RDPORT 8'h6c
`define CFRX_IDX_TXSTATE 8'h70

`define CFRX_ID_W 29
`define CFRX_ACCEPT_RST 16'h000f
`define CFRX_PATTERN_RST 29'h0000000
`define CFRX_OPTIONS_RST 1'b0

`define CFRX_CAP_LSB 0
`define CFRX_FREE_LSB 16
`define CFRX_WPP_LSB 0
`define CFRX_RPP_LSB 16
`define CFRX_EMPTY_BIT 0
`define CFRX_FULL_BIT 1
`define CFRX_MID_BIT 2
`define CFRX_FRC_LSB 4
`define CFRX_TS_BIT 0

`define CFRX_RESP_OKAY 2'b00
`define CFRX_RESP_DECERR 2'b11

`endif

/* File: include/cfrx_pkg.sv */
`default_nettype none
`include "cfrx_map.svh"
package cfrx_pkg;

	typedef enum logic [3:0] {
		buf_absent_state = 4'b0000,
		buf_ready_state = 4'b0001,
		buf_sending_state = 4'b0010,
		buf_abort_state = 4'b0011,
		buf_sent_ok_state = 4'b0100,
		buf_failed_state = 4'b0110,
		buf_aborted_state = 4'b0111,
		buf_empty_state = 4'b1000,
		buf_parity_fault_state = 4'b1001
	} cfrx_txstate_t;

	typedef logic [`CFRX_ID_W-1:0] cfrx_ident_t;

endpackage
`default_nettype wire

/* File: hdl/cfrx_regs.sv */
// Behaviour
// - third mask filter value: 29-bit identifier pattern, upper bits zero, reset zero
// - range filter low and high 29-bit bounds, reset zero, only when built
// - without range filter, bound writes ignored and reads return zero
// - 16-bit accept register, one active-high bit per filter per frame type
// - four bits per filter: classic base, classic ext, fd base, fd ext
// - after reset first filter accepts all four types, others accept none
// - read-only presence bits 0..3 for filters one to three and range
// - memory info bits 12..0 give receive buffer capacity in words
// - memory info bits 28..16 give current free words, tracking stores and auto-mode reads
// - write position bits 11..0 advance when a frame is stored, reset zero
// - read position bits 27..16 advance as frame words are read in auto mode
// - status bit 0 set when no frame stored, resets to one
// - status bit 1 set when every buffer word is occupied
// - status bit 2 set while a frame is partly read out
// - status bits 14..4 count complete stored frames, reset zero
// - options bit 0 picks timestamp point: 0 end of frame, 1 start
// - data port read returns word; advances only in auto mode when not empty
// - data port read when not empty sets parity flag when the word read has bad parity
// - transmit state register: 4 bits per buffer, up to eight buffers, built ones reset empty, others read absent
// - transmit state codes: absent, ready, sending, abort, ok, failed, etc
`timescale 1ns/10ps
`default_nettype none
`include "cfrx_map.svh"
module cfrx_regs
	import cfrx_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int RX_DEPTH = 1024,
	parameter int TXT_COUNT = 8,
	parameter bit FILT1_PRESENT = 1'b1,
	parameter bit FILT2_PRESENT = 1'b1,
	parameter bit FILT3_PRESENT = 1'b1,
	parameter bit RANGE_PRESENT = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_store_valid,
	input wire logic [31:0] rx_store_data,
	input wire logic rx_store_last,
	output logic rx_store_ready,
	input wire logic rx_auto_advance_mode,
	input wire logic rx_parity_error_clear,
	output logic rx_parity_error_flag,
	output logic rx_timestamp_point,
	output logic [28:0] third_filter_pattern,
	output logic [28:0] range_low_bound,
	output logic [28:0] range_high_bound,
	output logic [3:0] filt1_accept,
	output logic [3:0] filt2_accept,
	output logic [3:0] filt3_accept,
	output logic [3:0] range_accept,
	input wire logic [31:0] tx_state_in
);

	localparam int AW = $clog2(RX_DEPTH);

	if (RX_DEPTH < 4 || RX_DEPTH > 4096 ||
		(1 << AW) != RX_DEPTH) begin : g_bad_depth
		$error("rx depth must be a power of two from 4 to 4096");
	end
	if (TXT_COUNT < 2 || TXT_COUNT > 8) begin : g_bad_txt
		$error("transmit buffer count must be 2 to 8");
	end
	if (ADDR_W < 10) begin : g_bad_addr
		$error("address width too small for the register map");
	end

	function automatic logic [31:0] cfrx_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic cfrx_mapped(input logic [ADDR_W-3:0] idx);
		return idx == (ADDR_W-2)'(`CFRX_IDX_FILT3_VAL) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_RANGE_LOW) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_RANGE_HIGH) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_ACCEPT) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_PRESENT) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_MEMINFO) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_POINTERS) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_STATUS) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_OPTIONS) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_RDPORT) ||
			idx == (ADDR_W-2)'(`CFRX_IDX_TXSTATE);
	endfunction

	// bus handshake state
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [ADDR_W-3:0] aw_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// software registers
	cfrx_ident_t filt3_q, rlow_q, rhigh_q;
	logic [15:0] accept_q;
	logic ts_q;

	// receive buffer
	logic [33:0] mem_q [RX_DEPTH];
	logic [AW-1:0] wpp_q, wtmp_q, rpp_q;
	logic [AW:0] used_q, used_d;
	logic [10:0] frc_q;
	logic mid_q, parity_q, st_ready_q;

	logic do_wr, ar_fire, st_fire, st_commit, rd_port, rd_take, rd_adv;
	logic rx_empty, rx_full, rd_last, rd_bad;
	logic [ADDR_W-3:0] ar_idx;
	logic [33:0] rd_word;
	logic [12:0] free_w;
	logic [3:0] presence_w;
	logic [31:0] tx_state_w, rd_val, wr_val;
	logic rd_ok;

	assign do_wr = !awready_q && !wready_q && !bvalid_q;
	assign ar_fire = s_axi_arvalid && arready_q;
	assign ar_idx = s_axi_araddr[ADDR_W-1:2];
	assign st_fire = rx_store_valid && st_ready_q;
	assign st_commit = st_fire && rx_store_last;
	assign rd_port = ar_fire && ar_idx == (ADDR_W-2)'(`CFRX_IDX_RDPORT);
	assign rx_empty = frc_q == 11'h000;
	assign rx_full = used_q == (AW+1)'(RX_DEPTH);
	assign rd_word = mem_q[rpp_q];
	assign rd_last = rd_word[33];
	assign rd_bad = (^rd_word[31:0]) != rd_word[32];
	assign rd_take = rd_port && !rx_empty;
	// software must read the port as whole words here; byte lanes are not seen
	assign rd_adv = rd_take && rx_auto_advance_mode;
	assign free_w = 13'(RX_DEPTH) - 13'(used_q);
	assign presence_w = {RANGE_PRESENT, FILT3_PRESENT, FILT2_PRESENT,
		FILT1_PRESENT};
	assign wr_val = cfrx_merge(32'h00000000, wdata_q, wstrb_q);

	always_comb begin
		used_d = used_q;
		if (st_fire && !rd_adv)
			used_d = used_q + (AW+1)'(1);
		else if (!st_fire && rd_adv)
			used_d = used_q - (AW+1)'(1);
	end

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `CFRX_RESP_OKAY;
			aw_idx_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= cfrx_mapped(aw_idx_q) ? `CFRX_RESP_OKAY :
					`CFRX_RESP_DECERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// writable registers; a cleared strobe keeps the old byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt3_q <= `CFRX_PATTERN_RST;
			rlow_q <= `CFRX_PATTERN_RST;
			rhigh_q <= `CFRX_PATTERN_RST;
			accept_q <= `CFRX_ACCEPT_RST;
			ts_q <= `CFRX_OPTIONS_RST;
		end else if (do_wr) begin
			if (aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_FILT3_VAL) && FILT3_PRESENT)
				filt3_q <= 29'(cfrx_merge({3'b000, filt3_q}, wdata_q,
					wstrb_q));
			if (aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_RANGE_LOW) && RANGE_PRESENT)
				rlow_q <= 29'(cfrx_merge({3'b000, rlow_q}, wdata_q,
					wstrb_q));
			if (aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_RANGE_HIGH) && RANGE_PRESENT)
				rhigh_q <= 29'(cfrx_merge({3'b000, rhigh_q}, wdata_q,
					wstrb_q));
			if (aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_ACCEPT))
				accept_q <= 16'(cfrx_merge({16'h0000, accept_q}, wdata_q,
					wstrb_q));
			// changing this while the core runs may stamp a frame oddly
			if (aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_OPTIONS) && wstrb_q[0])
				ts_q <= wr_val[`CFRX_TS_BIT];
		end
	end

	// read mux; reserved bits and absent registers read zero
	always_comb begin
		rd_val = 32'h00000000;
		rd_ok = cfrx_mapped(ar_idx);
		if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_FILT3_VAL))
			rd_val = {3'b000, filt3_q};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_RANGE_LOW))
			rd_val = {3'b000, rlow_q};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_RANGE_HIGH))
			rd_val = {3'b000, rhigh_q};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_ACCEPT))
			rd_val = {16'h0000, accept_q};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_PRESENT))
			rd_val = {28'h0000000, presence_w};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_MEMINFO))
			rd_val = {3'b000, free_w, 3'b000, 13'(RX_DEPTH)};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_POINTERS))
			rd_val = {4'h0, 12'(rpp_q), 4'h0, 12'(wpp_q)};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_STATUS))
			rd_val = {17'h00000, frc_q, 1'b0, mid_q, rx_full,
				rx_empty};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_OPTIONS))
			rd_val = {31'h00000000, ts_q};
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_RDPORT))
			rd_val = rd_word[31:0];
		else if (ar_idx == (ADDR_W-2)'(`CFRX_IDX_TXSTATE))
			rd_val = tx_state_w;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= `CFRX_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (ar_fire) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_ok ? `CFRX_RESP_OKAY : `CFRX_RESP_DECERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// buffer storage: {frame last, even parity, word}
	always_ff @(posedge aclk) begin
		if (st_fire)
			mem_q[wtmp_q] <= {rx_store_last, ^rx_store_data, rx_store_data};
	end

	// a frame's words become visible only when its last word is stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wtmp_q <= '0;
			wpp_q <= '0;
		end else if (st_fire) begin
			wtmp_q <= wtmp_q + AW'(1);
			if (rx_store_last)
				wpp_q <= wtmp_q + AW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			rpp_q <= '0;
		else if (rd_adv)
			rpp_q <= rpp_q + AW'(1);
	end

	// the store side stalls once every word is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			used_q <= '0;
			st_ready_q <= 1'b1;
		end else begin
			used_q <= used_d;
			st_ready_q <= used_d != (AW+1)'(RX_DEPTH);
		end
	end

	// count wraps past 2047 only if frames of one or two words fill 4096 words
	always_ff @(posedge aclk) begin
		if (!aresetn)
			frc_q <= 11'h000;
		else if (st_commit && !(rd_adv && rd_last))
			frc_q <= frc_q + 11'h001;
		else if (!st_commit && rd_adv && rd_last)
			frc_q <= frc_q - 11'h001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mid_q <= 1'b0;
		else if (rd_adv)
			mid_q <= !rd_last;
	end

	// a new error wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			parity_q <= 1'b0;
		else if (rd_take && rd_bad)
			parity_q <= 1'b1;
		else if (rx_parity_error_clear)
			parity_q <= 1'b0;
	end

	for (genvar g = 0; g < 8; g++) begin : g_tx
		if (g < TXT_COUNT) begin : g_on
			cfrx_txstate_t st_q;
			always_ff @(posedge aclk) begin
				if (!aresetn)
					st_q <= buf_empty_state;
				else
					st_q <= cfrx_txstate_t'(tx_state_in[4*g +: 4]);
			end
			assign tx_state_w[4*g +: 4] = st_q;
		end else begin : g_off
			assign tx_state_w[4*g +: 4] = buf_absent_state;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign rx_store_ready = st_ready_q;
	assign rx_parity_error_flag = parity_q;
	assign rx_timestamp_point = ts_q;
	assign third_filter_pattern = filt3_q;
	assign range_low_bound = rlow_q;
	assign range_high_bound = rhigh_q;
	assign filt1_accept = accept_q[3:0];
	assign filt2_accept = accept_q[7:4];
	assign filt3_accept = accept_q[11:8];
	assign range_accept = accept_q[15:12];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	accept_reset_a: assert property ($past(!aresetn) |->
		accept_q == `CFRX_ACCEPT_RST && frc_q == 11'h000)
		else $error("accept bits or frame count wrong after reset");
	range_absent_a: assert property (!RANGE_PRESENT |->
		rlow_q == '0 && rhigh_q == '0)
		else $error("range bound changed while range filter absent");
	full_stall_a: assert property (rx_full |-> !st_ready_q)
		else $error("store side ready while buffer full");
	wpp_commit_a: assert property (st_commit |=>
		wpp_q == $past(wtmp_q) + AW'(1))
		else $error("write position did not follow stored frame");
	rpp_hold_a: assert property (rd_port && !rx_auto_advance_mode |=>
		$stable(rpp_q))
		else $error("read position moved outside auto mode");
	rpp_step_a: assert property (rd_adv |=>
		rpp_q == $past(rpp_q) + AW'(1) ##1
		!rvalid_q || rdata_q == $past(rd_word[31:0], 2))
		else $error("read position did not step on data read");
	free_track_a: assert property (st_fire && !rd_adv |=>
		free_w == $past(free_w) - 13'h0001)
		else $error("free count did not drop after store");
	frc_up_a: assert property (st_commit && !rd_adv |=>
		frc_q == $past(frc_q) + 11'h001 && !rx_empty)
		else $error("frame count did not rise on commit");
	parity_set_a: assert property (rd_take && rd_bad |=> parity_q)
		else $error("parity flag not set on bad word");
	mid_flag_a: assert property (rd_adv && !rd_last |=> mid_q)
		else $error("mid frame flag not set");
	read_answer_a: assert property (ar_fire |=> rvalid_q &&
		s_axi_rresp == ($past(rd_ok) ? `CFRX_RESP_OKAY :
		`CFRX_RESP_DECERR))
		else $error("read answer missing or wrong response");

	frame_stored_c: cover property (st_commit ##[1:20] rd_adv && rd_last);
	buffer_full_c: cover property (rx_full);
	accept_write_c: cover property (do_wr &&
		aw_idx_q == (ADDR_W-2)'(`CFRX_IDX_ACCEPT));
	unmapped_read_c: cover property (ar_fire && !rd_ok);

endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cfrx_map.svh"
module tb_top
	import cfrx_pkg::*;
;
	localparam logic [11:0] A_F3 = {2'b00, `CFRX_IDX_FILT3_VAL, 2'b00};
	localparam logic [11:0] A_LO = {2'b00, `CFRX_IDX_RANGE_LOW, 2'b00};
	localparam logic [11:0] A_HI = {2'b00, `CFRX_IDX_RANGE_HIGH, 2'b00};
	localparam logic [11:0] A_AC = {2'b00, `CFRX_IDX_ACCEPT, 2'b00};
	localparam logic [11:0] A_PR = {2'b00, `CFRX_IDX_PRESENT, 2'b00};
	localparam logic [11:0] A_MI = {2'b00, `CFRX_IDX_MEMINFO, 2'b00};
	localparam logic [11:0] A_PT = {2'b00, `CFRX_IDX_POINTERS, 2'b00};
	localparam logic [11:0] A_ST = {2'b00, `CFRX_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_OP = {2'b00, `CFRX_IDX_OPTIONS, 2'b00};
	localparam logic [11:0] A_RD = {2'b00, `CFRX_IDX_RDPORT, 2'b00};
	localparam logic [11:0] A_TX = {2'b00, `CFRX_IDX_TXSTATE, 2'b00};
	localparam logic [1:0] OK = `CFRX_RESP_OKAY;
	localparam logic [1:0] DE = `CFRX_RESP_DECERR;
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_store_data, tx_state_in;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, rx_store_valid, rx_store_last;
	logic rx_store_ready, rx_auto_advance_mode, rx_parity_error_clear;
	logic rx_parity_error_flag, rx_timestamp_point;
	logic [28:0] third_filter_pattern, range_low_bound, range_high_bound;
	logic [3:0] filt1_accept, filt2_accept, filt3_accept, range_accept;
	logic [31:0] rd, tv;
	int miscompares, n_checks, i, k;
	cfrx_txstate_t codes [9];

	cfrx_regs #(.RX_DEPTH(8)) i_cfrx_regs (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rx_store_valid(rx_store_valid),
		.rx_store_data(rx_store_data), .rx_store_last(rx_store_last),
		.rx_store_ready(rx_store_ready),
		.rx_auto_advance_mode(rx_auto_advance_mode),
		.rx_parity_error_clear(rx_parity_error_clear),
		.rx_parity_error_flag(rx_parity_error_flag),
		.rx_timestamp_point(rx_timestamp_point),
		.third_filter_pattern(third_filter_pattern),
		.range_low_bound(range_low_bound), .range_high_bound(range_high_bound),
		.filt1_accept(filt1_accept), .filt2_accept(filt2_accept),
		.filt3_accept(filt3_accept), .range_accept(range_accept),
		.tx_state_in(tx_state_in)
	);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic final_report();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang();
		miscompares++;
		$display("ERROR %0t: handshake timeout", $time);
		final_report();
	endtask

	// an idle edge first, so no handshake signal is assigned twice at one edge
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		bit aw_ok, w_ok;
		int n;
		@(posedge aclk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid) break;
			if (s_axi_awready && !aw_ok) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_ok) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (n == 40) hang();
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (n == 40) hang();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp,
			input logic [31:0] m = 32'hffff_ffff);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk({30'h0, r}, {30'h0, OK});
		chk(d & m, exp);
	endtask

	task automatic st_frame(input logic [31:0] base, input int n);
		int j, w;
		@(posedge aclk);
		for (j = 0; j < n; j++) begin
			rx_store_valid <= 1'b1;
			rx_store_data <= base + j;
			rx_store_last <= (j == n - 1);
			for (w = 0; w < 40; w++) begin
				@(posedge aclk);
				if (rx_store_ready) break;
			end
			if (w == 40) hang();
		end
		rx_store_valid <= 1'b0;
		rx_store_last <= 1'b0;
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, rx_store_valid, rx_store_last} = '0;
		{rx_store_data, rx_auto_advance_mode, rx_parity_error_clear} = '0;
		tx_state_in = 32'h8888_8888;
		miscompares = 0;
		n_checks = 0;
		codes = '{buf_absent_state, buf_ready_state, buf_sending_state,
			buf_abort_state, buf_sent_ok_state, buf_failed_state,
			buf_aborted_state, buf_empty_state, buf_parity_fault_state};
		do_reset();
		chk_rd(A_F3, 32'h0);
		chk_rd(A_LO, 32'h0);
		chk_rd(A_HI, 32'h0);
		chk_rd(A_AC, 32'h0000_000f);
		chk_rd(A_PR, 32'h0000_000f);
		chk_rd(A_MI, 32'h0008_0008);
		chk_rd(A_PT, 32'h0);
		chk_rd(A_ST, 32'h0000_0001);
		chk_rd(A_OP, 32'h0);
		chk_rd(A_TX, 32'h8888_8888);
		axi_wr(A_F3, 32'hffff_ffff, 4'hf, OK);
		chk_rd(A_F3, 32'h1fff_ffff);
		axi_wr(A_F3, 32'h0000_0055, 4'h1, OK);
		chk_rd(A_F3, 32'h1fff_ff55);
		chk({3'h0, third_filter_pattern}, 32'h1fff_ff55);
		axi_wr(A_LO, 32'h1234_5678, 4'hf, OK);
		axi_wr(A_HI, 32'he000_0001, 4'hf, OK);
		chk_rd(A_LO, 32'h1234_5678);
		chk_rd(A_HI, 32'h0000_0001);
		chk({3'h0, range_low_bound}, 32'h1234_5678);
		chk({3'h0, range_high_bound}, 32'h0000_0001);
		axi_wr(A_AC, 32'hffff_a5c3, 4'hf, OK);
		chk_rd(A_AC, 32'h0000_a5c3);
		chk({16'h0, range_accept, filt3_accept, filt2_accept, filt1_accept},
			32'h0000_a5c3);
		axi_wr(A_PR, 32'h0, 4'hf, OK);
		chk_rd(A_PR, 32'h0000_000f);
		axi_wr(A_MI, 32'h0, 4'hf, OK);
		chk_rd(A_MI, 32'h0008_0008);
		// no frame traffic yet, so the stamp point may change here
		axi_wr(A_OP, 32'hffff_ffff, 4'he, OK);
		chk_rd(A_OP, 32'h0);
		axi_wr(A_OP, 32'h0000_0001, 4'hf, OK);
		chk_rd(A_OP, 32'h0000_0001);
		chk({31'h0, rx_timestamp_point}, 32'h1);
		axi_wr(12'h3fc, 32'h1, 4'hf, DE);
		axi_rd(12'h3fc, rd, rsp);
		chk({30'h0, rsp}, {30'h0, DE});
		chk(rd, 32'h0);
		st_frame(32'ha000_0000, 3);
		chk_rd(A_PT, 32'h0000_0003);
		chk_rd(A_ST, 32'h0000_0010);
		chk_rd(A_MI, 32'h0005_0008);
		st_frame(32'hb000_0000, 5);
		chk_rd(A_ST, 32'h0000_0022);
		chk_rd(A_MI, 32'h0000_0008);
		rx_store_valid <= 1'b1;
		rx_store_last <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({31'h0, rx_store_ready}, 32'h0);
		rx_store_valid <= 1'b0;
		rx_store_last <= 1'b0;
		chk_rd(A_ST, 32'h0000_0022);
		rx_auto_advance_mode <= 1'b1;
		chk_rd(A_RD, 32'ha000_0000);
		chk_rd(A_ST, 32'h0000_0004, 32'h0000_0004);
		for (i = 1; i < 3; i++) chk_rd(A_RD, 32'ha000_0000 + i);
		chk_rd(A_ST, 32'h0000_0010);
		chk_rd(A_PT, 32'h0003_0000, 32'h0fff_0000);
		chk_rd(A_MI, 32'h0003_0008);
		rx_auto_advance_mode <= 1'b0;
		chk_rd(A_RD, 32'hb000_0000);
		chk_rd(A_RD, 32'hb000_0000);
		chk_rd(A_PT, 32'h0003_0000, 32'h0fff_0000);
		rx_auto_advance_mode <= 1'b1;
		for (i = 0; i < 5; i++) chk_rd(A_RD, 32'hb000_0000 + i);
		chk_rd(A_ST, 32'h0000_0001);
		chk_rd(A_MI, 32'h0008_0008);
		// empty buffer: the port shows the word at the read position
		chk_rd(A_RD, 32'ha000_0000);
		chk_rd(A_PT, 32'h0);
		chk_rd(A_ST, 32'h0000_0001);
		chk({31'h0, rx_parity_error_flag}, 32'h0);
		rx_parity_error_clear <= 1'b1;
		@(posedge aclk);
		rx_parity_error_clear <= 1'b0;
		for (i = 0; i < 9; i++) begin
			for (k = 0; k < 8; k++) tv[4*k +: 4] = codes[(i + k) % 9];
			tx_state_in <= tv;
			@(posedge aclk);
			chk_rd(A_TX, tv);
		end
		do_reset();
		chk_rd(A_AC, 32'h0000_000f);
		chk_rd(A_F3, 32'h0);
		chk_rd(A_OP, 32'h0);
		chk_rd(A_ST, 32'h0000_0001);
		final_report();
	end
endmodule
`default_nettype wire
